// ==== core/ddm_mem.sv ====
/*
  Memory module end: decodes commands on master clock rising edges, keeps bank
  state, serves bursts from a small array.
  Assumes core_clk is much faster than the master clock; all pins but master_clock_n synchronised.
*/
`timescale 1ns/1ps
module ddm_mem #(
  parameter int DEPTH = ddm_pkg::MEM_DEPTH
) (
  input  wire logic                       core_clk,
  input  wire logic                       srst,
  ddm_if.mem                              link,
  output logic [ddm_pkg::NBANK-1:0]       bank_open_r,
  output logic                            power_down_r,
  output logic                            busy_r
);
  // ==========================================================
  // Pin synchronisers
  logic [1:0] ck_s_r;
  logic       ck_d_r;
  logic [1:0] cke_s_r, sel_s_r, ras_s_r, cas_s_r, we_s_r, dqs_s_r, dm_s_r;
  logic [ddm_pkg::BANK_W-1:0] ba_s0_r, ba_s1_r;
  logic [ddm_pkg::ROW_W-1:0]  ad_s0_r, ad_s1_r;
  logic [ddm_pkg::DQ_W-1:0]   dq_s0_r, dq_s1_r;
  logic                       dqs_d_r;

  // Two flops on every incoming pin except master_clock_n, which is unused
  always_ff @(posedge core_clk) begin
    ck_s_r  <= {ck_s_r[0], link.master_clock};
    cke_s_r <= {cke_s_r[0], link.cke};
    sel_s_r <= {sel_s_r[0], link.sel_n};
    ras_s_r <= {ras_s_r[0], link.ras_n};
    cas_s_r <= {cas_s_r[0], link.cas_n};
    we_s_r  <= {we_s_r[0], link.we_n};
    dqs_s_r <= {dqs_s_r[0], link.dqs};
    dm_s_r  <= {dm_s_r[0], link.write_mask[0]};
    ba_s0_r <= link.bank_select;
    ba_s1_r <= ba_s0_r;
    ad_s0_r <= link.addr;
    ad_s1_r <= ad_s0_r;
    dq_s0_r <= link.dq;
    dq_s1_r <= dq_s0_r;
    ck_d_r  <= ck_s_r[1];
    dqs_d_r <= dqs_s_r[1];
  end

  // ==========================================================
  // Edge and command decode
  wire ck_rise  = ck_s_r[1] & ~ck_d_r;
  wire ck_fall  = ~ck_s_r[1] & ck_d_r;
  wire dqs_edge = dqs_s_r[1] ^ dqs_d_r;
  wire selected = ~sel_s_r[1] & ~power_down_r;
  wire [2:0] cmd = {ras_s_r[1], cas_s_r[1], we_s_r[1]};
  wire take     = ck_rise & selected;
  wire [ddm_pkg::BANK_W-1:0] bank = ba_s1_r;
  wire ap_bit   = ad_s1_r[ddm_pkg::AP_POS];
  wire is_act   = take & (cmd == ddm_pkg::CMD_ACT);
  wire is_pre   = take & (cmd == ddm_pkg::CMD_PRE);
  wire is_rd    = take & (cmd == ddm_pkg::CMD_RD) & ~busy_r;
  wire is_wr    = take & (cmd == ddm_pkg::CMD_WR) & ~busy_r;
  wire [ddm_pkg::COL_W-1:0] col_in = ad_s1_r[ddm_pkg::COL_W-1:0];

  // ==========================================================
  // Row, bank and power state
  logic [ddm_pkg::ROW_W-1:0] row_r [ddm_pkg::NBANK];
  logic [ddm_pkg::NBANK-1:0] open_nxt;

  // Bank registers and power-down
  always_ff @(posedge core_clk) begin
    if (srst) begin
      bank_open_r  <= '0;
      power_down_r <= 1'b0;
    end else begin
      bank_open_r <= open_nxt;
      if (ck_rise) begin
        power_down_r <= ~cke_s_r[1];
      end
    end
  end

  // Row latch on activate
  always_ff @(posedge core_clk) begin
    if (is_act) begin
      row_r[bank] <= ad_s1_r;
    end
  end

  // ==========================================================
  // Burst engine
  typedef enum logic [1:0] {DDM_IDLE, DDM_RLAT, DDM_RD, DDM_WR} ddm_bst_t;
  ddm_bst_t state_r;
  logic [2:0] lat_r, beat_r;
  logic [ddm_pkg::COL_W-1:0] col_r;
  logic [ddm_pkg::BANK_W-1:0] bbank_r;
  logic ap_r;
  logic [ddm_pkg::DQ_W-1:0] mem_r [DEPTH];
  localparam int AW = $clog2(DEPTH);
  wire [AW-1:0] maddr = AW'({bbank_r, col_r} + (ddm_pkg::COL_W+ddm_pkg::BANK_W)'(beat_r));
  wire burst_end = (state_r == DDM_RD || state_r == DDM_WR) &&
                   beat_r == 3'(ddm_pkg::BURST_LEN) && ck_rise;

  // Open or close banks
  always_comb begin
    open_nxt = bank_open_r;
    if (is_act) begin
      open_nxt[bank] = 1'b1;
    end
    if (is_pre) begin
      if (ap_bit) begin
        open_nxt = '0;
      end else begin
        open_nxt[bank] = 1'b0;
      end
    end
    if (burst_end & ap_r) begin
      open_nxt[bbank_r] = 1'b0;
    end
  end

  // Burst sequencing, runs regardless of select
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r    <= DDM_IDLE;
      busy_r     <= 1'b0;
      lat_r      <= '0;
      beat_r     <= '0;
      col_r      <= '0;
      bbank_r    <= '0;
      ap_r       <= 1'b0;
      link.dqs_mem_o  <= 1'b0;
      link.dqs_mem_oe <= 1'b0;
      link.dq_mem_o   <= '0;
      link.dq_mem_oe  <= 1'b0;
    end else begin
      unique case (state_r)
        DDM_IDLE: begin
          if (is_rd | is_wr) begin
            state_r <= is_rd ? DDM_RLAT : DDM_WR;
            col_r   <= col_in;
            bbank_r <= bank;
            ap_r    <= ap_bit;
            lat_r   <= '0;
            beat_r  <= '0;
            busy_r  <= 1'b1;
          end
        end
        DDM_RLAT: begin
          if (ck_rise) begin
            lat_r <= lat_r + 3'h1;
            if (lat_r == 3'(ddm_pkg::RD_LAT - 1)) begin
              state_r         <= DDM_RD;
              link.dqs_mem_oe <= 1'b1;
              link.dq_mem_oe  <= 1'b1;
            end
          end
        end
        DDM_RD: begin
          // One beat per master clock edge
          if ((ck_rise | ck_fall) && beat_r != 3'(ddm_pkg::BURST_LEN)) begin
            link.dq_mem_o  <= mem_r[maddr];
            link.dqs_mem_o <= ~link.dqs_mem_o;                  // Edge per beat
            beat_r         <= beat_r + 3'h1;
          end
          if (burst_end) begin
            state_r         <= DDM_IDLE;
            busy_r          <= 1'b0;
            link.dqs_mem_oe <= 1'b0;
            link.dq_mem_oe  <= 1'b0;
            link.dqs_mem_o  <= 1'b0;
          end
        end
        DDM_WR: begin
          if (dqs_edge && beat_r != 3'(ddm_pkg::BURST_LEN)) begin
            beat_r <= beat_r + 3'h1;
          end
          if (burst_end) begin
            state_r <= DDM_IDLE;
            busy_r  <= 1'b0;
          end
        end
      endcase
    end
  end

  // Write data captured on strobe edges, mask honoured
  always_ff @(posedge core_clk) begin
    if (state_r == DDM_WR && dqs_edge && beat_r != 3'(ddm_pkg::BURST_LEN) && !dm_s_r[1]) begin
      mem_r[maddr] <= dq_s1_r;
    end
  end
endmodule

// ==== core/ddm_pkg.sv ====
/*
  Shared constants for the memory module link and its controller end.
  Assumes both ends run on core_clk at 20 MHz and a master clock made by the controller.
*/
package ddm_pkg;
  // ==========================================================
  // Widths
  localparam int ROW_W  = 14;
  localparam int COL_W  = 10;
  localparam int BANK_W = 3;
  localparam int NBANK  = 8;
  localparam int DQ_W   = 8;
  localparam int DM_W   = 1;
  localparam int AP_POS = 10;
  // ==========================================================
  // Timing: periods in ns, MCLK_HALF in core_clk cycles, RD_LAT in master clock rises, BURST_LEN in beats
  localparam int CLK_PERIOD_NS = 50;
  localparam int MCLK_NS       = 400;
  localparam int MCLK_HALF     = MCLK_NS / CLK_PERIOD_NS / 2;
  localparam int BURST_LEN     = 4;
  localparam int RD_LAT        = 2;
  localparam int WR_LAT        = 1;
  localparam int MEM_DEPTH     = 64;
  // ==========================================================
  // Commands as {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR  = 3'h4;
  localparam logic [2:0] CMD_RD  = 3'h5;
  localparam logic [2:0] CMD_NOP = 3'h7;
  // Host request codes
  typedef enum logic [2:0] {
    DDM_REQ_ACT, DDM_REQ_RD, DDM_REQ_WR, DDM_REQ_PRE, DDM_REQ_REF, DDM_REQ_PD
  } ddm_req_t;
endpackage

// ==== core/ddm_if.sv ====
/*
  Pin bundle between the memory module end and the controller end.
  Assumes the bench joins the mem modport, and the host modport or hand-driven pins; strobe and data levels resolve here.
*/
`timescale 1ns/1ps
interface ddm_if;
  logic                        master_clock;
  logic                        master_clock_n;
  logic                        cke;
  logic                        sel_n;
  logic                        ras_n;
  logic                        cas_n;
  logic                        we_n;
  logic [ddm_pkg::BANK_W-1:0]  bank_select;
  logic [ddm_pkg::ROW_W-1:0]   addr;
  logic [ddm_pkg::DM_W-1:0]    write_mask;
  // Two-way strobe and data, driver side per party
  logic                        dqs_mem_o;
  logic                        dqs_mem_oe;
  logic                        dqs_host_o;
  logic                        dqs_host_oe;
  logic [ddm_pkg::DQ_W-1:0]    dq_mem_o;
  logic                        dq_mem_oe;
  logic [ddm_pkg::DQ_W-1:0]    dq_host_o;
  logic                        dq_host_oe;
  // Resolved wire levels
  logic                        dqs;
  logic [ddm_pkg::DQ_W-1:0]    dq;
  assign dqs = dqs_mem_oe ? dqs_mem_o : (dqs_host_oe ? dqs_host_o : 1'b0);
  assign dq  = dq_mem_oe ? dq_mem_o : (dq_host_oe ? dq_host_o : '0);
  modport mem (
    input  master_clock, master_clock_n, cke, sel_n, ras_n, cas_n, we_n,
    input  bank_select, addr, write_mask, dqs, dq,
    output dqs_mem_o, dqs_mem_oe, dq_mem_o, dq_mem_oe
  );
  modport host (
    output master_clock, master_clock_n, cke, sel_n, ras_n, cas_n, we_n,
    output bank_select, addr, write_mask, dqs_host_o, dqs_host_oe, dq_host_o, dq_host_oe,
    input  dqs, dq
  );
endinterface

// ==== core/ddm_host.sv ====
/*
  Controller end: makes the master clock by dividing core_clk, holds each
  command one master clock period then deselects for one, and runs write and read bursts.
  Assumes the user holds a request until req_ready is seen.
*/
`timescale 1ns/1ps
module ddm_host (
  input  wire logic                       core_clk,
  input  wire logic                       srst,
  ddm_if.host                             link,
  input  wire logic                       req_valid,
  input  wire ddm_pkg::ddm_req_t          req_kind,
  input  wire logic [ddm_pkg::BANK_W-1:0] req_bank,
  input  wire logic [ddm_pkg::ROW_W-1:0]  req_addr,
  input  wire logic [ddm_pkg::DQ_W-1:0]   req_wdata,
  input  wire logic                       req_mask,
  output logic                            req_ready_r,
  output logic [ddm_pkg::DQ_W-1:0]        rd_data_r,
  output logic                            rd_valid_r
);
  // ==========================================================
  // Master clock divider
  logic [3:0] div_r;
  logic       mclk_r;
  logic       mclk_n_r;
  logic [ddm_pkg::DQ_W-1:0] wdata_r;
  logic       mask_r;
  wire        half  = div_r == 4'(ddm_pkg::MCLK_HALF - 1);
  wire        fall_next = half & mclk_r;
  wire        rise_next = half & ~mclk_r;
  logic [1:0] dqs_s_r;
  logic [ddm_pkg::DQ_W-1:0] dq_s0_r, dq_s1_r;
  logic       dqs_d_r;
  logic [2:0] beat_r;
  typedef enum logic [1:0] {DDM_H_IDLE, DDM_H_CMD, DDM_H_WR, DDM_H_RD} ddm_hst_t;
  ddm_hst_t st_r;

  // Divider, commands change on falling master edge
  always_ff @(posedge core_clk) begin
    if (srst) begin
      div_r    <= '0;
      mclk_r   <= 1'b0;
      mclk_n_r <= 1'b1;
    end else begin
      div_r  <= half ? 4'h0 : div_r + 4'h1;
      if (half) begin
        mclk_r   <= ~mclk_r;
        mclk_n_r <= mclk_r;
      end
    end
  end
  assign link.master_clock   = mclk_r;
  assign link.master_clock_n = mclk_n_r;

  // Read strobe sync
  always_ff @(posedge core_clk) begin
    dqs_s_r <= {dqs_s_r[0], link.dqs};
    dqs_d_r <= dqs_s_r[1];
    dq_s0_r <= link.dq;
    dq_s1_r <= dq_s0_r;
  end
  wire dqs_edge = dqs_s_r[1] ^ dqs_d_r;

  // Command issue and burst control
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= DDM_H_IDLE;
      req_ready_r <= 1'b0;
      rd_valid_r  <= 1'b0;
      rd_data_r   <= '0;
      beat_r      <= '0;
      wdata_r     <= '0;
      mask_r      <= 1'b0;
      link.cke    <= 1'b1;
      link.sel_n  <= 1'b1;
      {link.ras_n, link.cas_n, link.we_n} <= ddm_pkg::CMD_NOP;
      link.bank_select <= '0;
      link.addr        <= '0;
      link.write_mask  <= '0;
      link.dqs_host_o  <= 1'b0;
      link.dqs_host_oe <= 1'b0;
      link.dq_host_o   <= '0;
      link.dq_host_oe  <= 1'b0;
    end else begin
      req_ready_r <= 1'b0;
      rd_valid_r  <= 1'b0;
      unique case (st_r)
        DDM_H_IDLE: begin
          if (fall_next) begin
            link.sel_n <= 1'b1;
            {link.ras_n, link.cas_n, link.we_n} <= ddm_pkg::CMD_NOP;
            if (req_valid) begin
              st_r        <= DDM_H_CMD;
              req_ready_r <= 1'b1;
              link.cke    <= req_kind != ddm_pkg::DDM_REQ_PD;
              link.sel_n  <= req_kind == ddm_pkg::DDM_REQ_PD;
              link.bank_select <= req_bank;
              link.addr        <= req_addr;
              beat_r           <= '0;
              wdata_r          <= req_wdata;                    // Held for the burst
              mask_r           <= req_mask;
              unique case (req_kind)
                ddm_pkg::DDM_REQ_ACT: {link.ras_n, link.cas_n, link.we_n} <= ddm_pkg::CMD_ACT;
                ddm_pkg::DDM_REQ_RD:  {link.ras_n, link.cas_n, link.we_n} <= ddm_pkg::CMD_RD;
                ddm_pkg::DDM_REQ_WR:  {link.ras_n, link.cas_n, link.we_n} <= ddm_pkg::CMD_WR;
                ddm_pkg::DDM_REQ_PRE: {link.ras_n, link.cas_n, link.we_n} <= ddm_pkg::CMD_PRE;
                ddm_pkg::DDM_REQ_REF: {link.ras_n, link.cas_n, link.we_n} <= ddm_pkg::CMD_REF;
                default:              {link.ras_n, link.cas_n, link.we_n} <= ddm_pkg::CMD_NOP;
              endcase
            end
          end
        end
        DDM_H_CMD: begin
          // Hold command a full period, then deselect
          if (fall_next) begin
            link.sel_n <= 1'b1;
            {link.ras_n, link.cas_n, link.we_n} <= ddm_pkg::CMD_NOP;
            if ({link.ras_n, link.cas_n, link.we_n} == ddm_pkg::CMD_WR) begin
              st_r <= DDM_H_WR;
              link.dq_host_oe  <= 1'b1;
              link.dqs_host_oe <= 1'b1;
            end else if ({link.ras_n, link.cas_n, link.we_n} == ddm_pkg::CMD_RD) begin
              st_r <= DDM_H_RD;
            end else begin
              st_r <= DDM_H_IDLE;
            end
          end
        end
        DDM_H_WR: begin
          // Strobe toggles at master edges, data set a half step ahead
          if (rise_next | fall_next) begin
            if (beat_r == 3'(ddm_pkg::BURST_LEN)) begin
              st_r <= DDM_H_IDLE;
              link.dq_host_oe  <= 1'b0;
              link.dqs_host_oe <= 1'b0;
              link.dqs_host_o  <= 1'b0;
            end else begin
              link.dqs_host_o <= ~link.dqs_host_o;
              beat_r <= beat_r + 3'h1;
            end
          end else if (div_r == 4'h1) begin
            link.dq_host_o     <= wdata_r ^ {ddm_pkg::DQ_W{beat_r[0]}};
            link.write_mask[0] <= mask_r;
          end
        end
        DDM_H_RD: begin
          if (dqs_edge) begin
            rd_data_r  <= dq_s1_r;
            rd_valid_r <= 1'b1;
            beat_r     <= beat_r + 3'h1;
          end
          if (beat_r == 3'(ddm_pkg::BURST_LEN)) begin
            st_r <= DDM_H_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// ==== dv/ddm_monitor.sv ====
/*
  Checker on the pins of the link that joins the two ends.
  Assumes instantiation beside that interface with core_clk and srst.
*/
`timescale 1ns/1ps
module ddm_monitor (
  input  wire logic                       core_clk,
  input  wire logic                       srst,
  input  wire logic                       master_clock,
  input  wire logic                       master_clock_n,
  input  wire logic                       cke,
  input  wire logic                       sel_n,
  input  wire logic                       ras_n,
  input  wire logic                       cas_n,
  input  wire logic                       we_n,
  input  wire logic [ddm_pkg::BANK_W-1:0] bank_select,
  input  wire logic [ddm_pkg::ROW_W-1:0]  addr,
  input  wire logic [ddm_pkg::DM_W-1:0]   write_mask,
  input  wire logic                       dqs_mem_o,
  input  wire logic                       dqs_mem_oe,
  input  wire logic                       dqs_host_oe,
  input  wire logic                       dqs,
  input  wire logic [ddm_pkg::DQ_W-1:0]   dq
);
  // ==========================================================
  // Cycles since the last read command
  logic [7:0] since_rd_r;
  logic [7:0] since_rd_nxt;
  logic       rd_cmd;
  assign rd_cmd = !sel_n && ({ras_n, cas_n, we_n} == ddm_pkg::CMD_RD);
  assign since_rd_nxt = (since_rd_r == 8'hFF) ? 8'hFF : since_rd_r + 8'h01;
  // Restart while a read is seen with clock high
  always_ff @(posedge core_clk) begin
    if (srst) since_rd_r <= 8'hFF;
    else if (master_clock && rd_cmd) since_rd_r <= 8'h00;
    else since_rd_r <= since_rd_nxt;
  end
  // ==========================================================
  // Assertions
  default clocking mon_cb @(posedge core_clk); endclocking
  default disable iff (srst);
  AST_CMD_STABLE: assert property ($rose(master_clock) |->
    $stable({sel_n, ras_n, cas_n, we_n, bank_select, addr})) else $error("Pins moved at rise");
  AST_CLK_PAIR: assert property (master_clock_n == !master_clock)
    else $error("Clock pair not inverse");
  AST_CLK_HALF: assert property ($rose(master_clock) |->
    master_clock[*4] ##1 !master_clock) else $error("Clock half period wrong");
  AST_CKE_HOLD: assert property ($changed(cke) |=> $stable(cke)[*7])
    else $error("Clock enable held too briefly");
  AST_STROBE_OWNER: assert property (!(dqs_mem_oe && dqs_host_oe))
    else $error("Both ends drive the strobe");
  AST_NOP_GAP: assert property ($fell(sel_n) |-> !sel_n[*8] ##1 sel_n)
    else $error("Select not held one master period");
  AST_WR_CENTER: assert property ((dqs_host_oe && $past(dqs_host_oe) && $changed(dqs)) |->
    $stable(dq) && $stable(write_mask)) else $error("Write data moved at strobe edge");
  AST_RD_SPACING: assert property ((dqs_mem_oe && $changed(dqs_mem_o)) |=>
    $stable(dqs_mem_o)[*3]) else $error("Read strobe toggles too fast");
  AST_RD_CAUSE: assert property ($rose(dqs_mem_oe) |-> since_rd_r < 8'h40)
    else $error("Module drove strobe without read");
  // Main scenarios
  cover property ($rose(dqs_mem_oe));
  cover property ($rose(dqs_host_oe));
  cover property ($fell(cke));
endmodule

// ==== dv/tb_top.sv ====
/*
  Bench: controller end and module end joined over one link, plus a second
  module end whose controller side the bench drives by hand.
  Assumes package, interface and both ends are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  // ==========================================================
  // Clocks, reset, counters, user side
  logic               core_clk = 1'b0;
  logic               srst = 1'b1;
  logic               mclk_b = 1'b0;
  int                 miscompares = 0;
  int                 checks_done = 0;
  logic               req_valid = 1'b0;
  ddm_pkg::ddm_req_t  req_kind = ddm_pkg::DDM_REQ_ACT;
  logic [2:0]         req_bank = 3'h0;
  logic [13:0]        req_addr = 14'h0000;
  logic [7:0]         req_wdata = 8'h00;
  logic               req_mask = 1'b0;
  logic               req_ready_r;
  logic               rd_valid_r;
  logic [7:0]         rd_data_r;
  logic [7:0]         bank_open_r;
  logic [7:0]         bank_open_b;
  logic               power_down_r;
  logic               power_down_b;
  logic               busy_r;
  always #25 core_clk = ~core_clk;
  initial #37 forever #200 mclk_b = ~mclk_b;
  // ==========================================================
  // Links, ends and checker
  ddm_if link_a ();
  ddm_if link_b ();
  assign link_b.master_clock = mclk_b;
  assign link_b.master_clock_n = ~mclk_b;
  ddm_host u_ddm_host (.core_clk(core_clk), .srst(srst), .link(link_a), .req_valid(req_valid),
    .req_kind(req_kind), .req_bank(req_bank), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_mask(req_mask), .req_ready_r(req_ready_r), .rd_data_r(rd_data_r),
    .rd_valid_r(rd_valid_r));
  ddm_mem u_ddm_mem (.core_clk(core_clk), .srst(srst), .link(link_a),
    .bank_open_r(bank_open_r), .power_down_r(power_down_r), .busy_r(busy_r));
  ddm_mem u_ddm_mem_b (.core_clk(core_clk), .srst(srst), .link(link_b),
    .bank_open_r(bank_open_b), .power_down_r(power_down_b), .busy_r());
  ddm_monitor u_ddm_monitor (.core_clk(core_clk), .srst(srst),
    .master_clock(link_a.master_clock), .master_clock_n(link_a.master_clock_n),
    .cke(link_a.cke), .sel_n(link_a.sel_n), .ras_n(link_a.ras_n), .cas_n(link_a.cas_n),
    .we_n(link_a.we_n), .bank_select(link_a.bank_select), .addr(link_a.addr),
    .write_mask(link_a.write_mask), .dqs_mem_o(link_a.dqs_mem_o),
    .dqs_mem_oe(link_a.dqs_mem_oe), .dqs_host_oe(link_a.dqs_host_oe),
    .dqs(link_a.dqs), .dq(link_a.dq));
  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Status picked by number
  function automatic logic [7:0] probe(input int w);
    case (w)
      0: return bank_open_r;
      1: return bank_open_b;
      default: return {7'h00, power_down_r};
    endcase
  endfunction
  // Wait bounded for a status value, then compare
  task automatic poll(input string nm, input int w, input logic [7:0] exp);
    int n;
    for (n = 0; n < 80 && probe(w) !== exp; n++) @(posedge core_clk);
    chk(nm, {8'h00, probe(w)}, {8'h00, exp});
    if (probe(w) !== exp) wrap_up();
  endtask
  // One user request held until taken
  task automatic req(input ddm_pkg::ddm_req_t k, input logic [2:0] b, input logic [13:0] a,
                     input logic [7:0] d, input logic m);
    int n;
    @(posedge core_clk);
    #1;
    req_kind  = k;
    req_bank  = b;
    req_addr  = a;
    req_wdata = d;
    req_mask  = m;
    req_valid = 1'b1;
    for (n = 0; n < 400 && req_ready_r !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    req_valid = 1'b0;
    if (n == 400) begin
      chk("req_ready", 16'h0000, 16'h0001);
      wrap_up();
    end
  endtask
  // Read burst, beats alternate data and its inverse
  task automatic rd_burst(input logic [2:0] b, input logic [13:0] a, input logic [7:0] d);
    int n;
    int got;
    got = 0;
    req(ddm_pkg::DDM_REQ_RD, b, a, 8'h00, 1'b0);
    for (n = 0; n < 300; n++) begin
      @(posedge core_clk);
      #1;
      if (rd_valid_r === 1'b1) begin
        if (got == 0) chk("busy_rd", {15'h0000, busy_r}, 16'h0001);
        chk("rd_beat", {8'h00, rd_data_r}, {8'h00, d ^ {8{got[0]}}});
        got++;
      end
    end
    chk("rd_beats", got[15:0], 16'h0004);
  endtask
  // Hand-driven command on the second link, then idle periods
  task automatic lb_cmd(input logic s, input logic [2:0] c, input logic [2:0] b,
                        input logic [13:0] a);
    @(negedge mclk_b);
    @(posedge core_clk);
    #1;
    {link_b.sel_n, link_b.ras_n, link_b.cas_n, link_b.we_n} = {s, c};
    {link_b.bank_select, link_b.addr} = {b, a};
    @(negedge mclk_b);
    @(posedge core_clk);
    #1;
    {link_b.sel_n, link_b.ras_n, link_b.cas_n, link_b.we_n} = {1'b1, ddm_pkg::CMD_NOP};
    repeat (2) @(negedge mclk_b);
  endtask
  // ==========================================================
  // Scenarios
  // Activate, write, read back; masked write keeps old data
  task automatic sc_burst();
    req(ddm_pkg::DDM_REQ_ACT, 3'h5, 14'h2ABC, 8'h00, 1'b0);
    poll("bank_open", 0, 8'h20);
    req(ddm_pkg::DDM_REQ_WR, 3'h5, 14'h0008, 8'hA5, 1'b0);
    rd_burst(3'h5, 14'h0008, 8'hA5);
    req(ddm_pkg::DDM_REQ_WR, 3'h5, 14'h0008, 8'h3C, 1'b1);
    rd_burst(3'h5, 14'h0008, 8'hA5);
  endtask
  // Single-bank and all-bank precharge
  task automatic sc_precharge();
    req(ddm_pkg::DDM_REQ_ACT, 3'h2, 14'h0001, 8'h00, 1'b0);
    poll("bank_open", 0, 8'h24);
    req(ddm_pkg::DDM_REQ_PRE, 3'h5, 14'h0000, 8'h00, 1'b0);
    poll("bank_open", 0, 8'h04);
    req(ddm_pkg::DDM_REQ_ACT, 3'h7, 14'h3FFF, 8'h00, 1'b0);
    poll("bank_open", 0, 8'h84);
    req(ddm_pkg::DDM_REQ_PRE, 3'h0, 14'h0400, 8'h00, 1'b0);
    poll("bank_open", 0, 8'h00);
  endtask
  // Read with automatic precharge closes the bank
  task automatic sc_autopre();
    req(ddm_pkg::DDM_REQ_ACT, 3'h7, 14'h0010, 8'h00, 1'b0);
    poll("bank_open", 0, 8'h80);
    rd_burst(3'h7, 14'h0408, 8'hA5);
    poll("bank_open", 0, 8'h00);
  endtask
  // Power-down entry, exit by next request
  task automatic sc_power();
    req(ddm_pkg::DDM_REQ_PD, 3'h0, 14'h0000, 8'h00, 1'b0);
    poll("power_down", 2, 8'h01);
    req(ddm_pkg::DDM_REQ_REF, 3'h0, 14'h0000, 8'h00, 1'b0);
    poll("power_down", 2, 8'h00);
  endtask
  // Deselected command ignored, then every bank code
  task automatic sc_select_b();
    lb_cmd(1'b1, ddm_pkg::CMD_ACT, 3'h3, 14'h0000);
    chk("desel_ignored", {8'h00, bank_open_b}, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      lb_cmd(1'b0, ddm_pkg::CMD_ACT, i[2:0], 14'h1234);
      chk("bank_code", {8'h00, bank_open_b}, 16'h00FF >> (7 - i));
    end
    lb_cmd(1'b0, ddm_pkg::CMD_PRE, 3'h4, 14'h0000);
    chk("pre_one", {8'h00, bank_open_b}, 16'h00EF);
    lb_cmd(1'b1, ddm_pkg::CMD_PRE, 3'h0, 14'h0400);
    chk("desel_pre", {8'h00, bank_open_b}, 16'h00EF);
    lb_cmd(1'b0, ddm_pkg::CMD_PRE, 3'h0, 14'h0400);
    lb_cmd(1'b0, ddm_pkg::CMD_MRS, 3'h0, 14'h0000);
    chk("pre_all", {8'h00, bank_open_b}, 16'h0000);
  endtask
  // Clock enable held until the third master clock fall each way
  task automatic sc_cke_b();
    @(negedge mclk_b);
    @(posedge core_clk);
    #1;
    link_b.cke = 1'b0;
    repeat (3) @(negedge mclk_b);
    chk("pd_enter", {15'h0000, power_down_b}, 16'h0001);
    @(posedge core_clk);
    #1;
    link_b.cke = 1'b1;
    repeat (3) @(negedge mclk_b);
    chk("pd_exit", {15'h0000, power_down_b}, 16'h0000);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {link_b.cke, link_b.sel_n, link_b.ras_n, link_b.cas_n, link_b.we_n} = 5'h1F;
    {link_b.bank_select, link_b.addr, link_b.write_mask} = '0;
    {link_b.dqs_host_o, link_b.dqs_host_oe, link_b.dq_host_o, link_b.dq_host_oe} = '0;
    repeat (16) @(posedge core_clk);
    #1;
    srst = 1'b0;
    sc_burst();
    sc_precharge();
    sc_autopre();
    sc_power();
    sc_select_b();
    sc_cke_b();
    wrap_up();
  end
endmodule
